// ---- core/pst_base_clock.v ----
`timescale 1ns/1ps
`include "pst_map.vh"

// Trimmed tick generator standing in for the RC oscillator
module pst_base_clock #(
    parameter CLK_KHZ = `PST_CLK_KHZ,
    parameter BASE_KHZ = `PST_BASE_KHZ
) (
    input wire clk,
    input wire rst,
    input wire [3:0] oscFreqTrim,
    output reg baseTick
);
    localparam integer NOMDIV = CLK_KHZ / BASE_KHZ;
    reg [7:0] divCnt_q;
    wire [7:0] divEnd;

    // Trim moves the period by -8..+7 steps around nominal
    assign divEnd = NOMDIV[7:0] + {4'h0, oscFreqTrim} - 8'h08 - 8'h01;

    always @(posedge clk) begin
        if (rst) begin
            divCnt_q <= 8'h00;
            baseTick <= 1'b0;
        end else if (divCnt_q >= divEnd) begin
            divCnt_q <= 8'h00;
            baseTick <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
            baseTick <= 1'b0;
        end
    end
endmodule // pst_base_clock

// ---- core/pst_panel_timing.v ----
`timescale 1ns/1ps
`include "pst_map.vh"

module pst_panel_timing #(
    parameter ROWS = `PST_ROWS,
    parameter COLS = `PST_COLS,
    parameter CLK_KHZ = `PST_CLK_KHZ
) (
    input wire clk,
    input wire rst,
    input wire syncOnCmd,
    input wire syncOffCmd,
    input wire [7:0] syncOnParam,
    input wire rgbIfActive,
    input wire sleepIn,
    input wire [8:0] syncLineDelay,
    input wire [3:0] oscFreqTrim,
    input wire rowInterleave,
    input wire rowOrderFlip,
    input wire [5:0] pixelLevel,
    input wire [37:0] grayAdjPos,
    input wire [37:0] grayAdjNeg,
    output reg panelSyncPulse,
    output reg [ROWS-1:0] rowOn,
    output reg [COLS-1:0] colPolarity,
    output reg [5:0] colLevel,
    output reg [37:0] grayAdjActive,
    output reg baseTickOut
);
    localparam integer HHIGH_CYC = `PST_HHIGH_MAX_US * (CLK_KHZ / 1000);
    // Row count and half row count at the width of the line counter
    localparam [8:0] ROWS9 = ROWS[8:0];
    localparam [8:0] HALF9 = ROWS9 >> 1;
    localparam [2:0] ST_VBLANK = 3'b001;
    localparam [2:0] ST_ACTIVE = 3'b010;
    localparam [2:0] ST_HBLANK = 3'b100;

    wire baseTick;
    reg syncEn_q;
    reg syncMode_q;
    reg [2:0] state_q;
    reg [15:0] tick_q;
    reg [8:0] line_q;
    reg [8:0] scanRow;
    reg [19:0] highCnt_q;
    reg framePol_q;
    reg syncRaw;
    wire [8:0] half;
    wire lineEnd;

    ////////////////////////////////////////////////////////////////////////
    pst_base_clock #(
        .CLK_KHZ(CLK_KHZ)
    ) u_base (
        .clk(clk),
        .rst(rst),
        .oscFreqTrim(oscFreqTrim),
        .baseTick(baseTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command latch for sync output
    always @(posedge clk) begin
        if (rst) begin
            syncEn_q <= 1'b0;
            syncMode_q <= `PST_MODE_VBLANK;
        end else if (syncOnCmd) begin
            syncEn_q <= 1'b1;
            syncMode_q <= syncOnParam[0];
        end else if (syncOffCmd) begin
            syncEn_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line and frame sequencer
    assign lineEnd = baseTick && (tick_q == `PST_LINE_TICKS - 16'd1);

    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_VBLANK;
            tick_q <= 16'd0;
            line_q <= 9'd0;
            framePol_q <= 1'b0;
        end else begin
            if (baseTick) begin
                tick_q <= lineEnd ? 16'd0 : tick_q + 16'd1;
            end
            case (state_q)
                ST_VBLANK: begin
                    if (lineEnd) begin
                        if (line_q == `PST_VBLANK_LINES - 9'd1) begin
                            state_q <= ST_HBLANK;
                            line_q <= 9'd0;
                        end else begin
                            line_q <= line_q + 9'd1;
                        end
                    end
                end
                ST_HBLANK: begin
                    // Blank part of the line ends, refresh of the row starts
                    if (baseTick
                        && tick_q == `PST_LINE_BLANK_TICKS - 16'd1) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (lineEnd) begin
                        if (line_q == ROWS9 - 9'd1) begin
                            state_q <= ST_VBLANK;
                            line_q <= 9'd0;
                            framePol_q <= ~framePol_q;
                        end else begin
                            state_q <= ST_HBLANK;
                            line_q <= line_q + 9'd1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_VBLANK;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan order
    assign half = HALF9;

    always @* begin
        if (!rowInterleave) begin
            // Progressive scan, top down or bottom up
            if (rowOrderFlip) begin
                scanRow = ROWS9 - 9'd1 - line_q;
            end else begin
                scanRow = line_q;
            end
        end else if (!rowOrderFlip) begin
            // Index 0 is row 1: odd rows first, then even rows
            if (line_q < half) begin
                scanRow = {line_q[7:0], 1'b0};
            end else begin
                scanRow = {line_q[7:0] - half[7:0], 1'b1};
            end
        end else begin
            // Flipped: even rows from the bottom, then odd rows
            if (line_q < half) begin
                scanRow = ROWS9 - 9'd1
                    - {line_q[7:0], 1'b0};
            end else begin
                scanRow = ROWS9 - 9'd2
                    - {line_q[7:0] - half[7:0], 1'b0};
            end
        end
    end

    genvar r;
    generate
        for (r = 0; r < ROWS; r = r + 1) begin : g_row
            always @(posedge clk) begin
                if (rst) begin
                    rowOn[r] <= 1'b0;
                end else begin
                    // Only the row being refreshed sits at the on level
                    rowOn[r] <= (state_q == ST_ACTIVE)
                        && (scanRow == r);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Column polarity alternates per column, per line and per frame
    genvar c;
    generate
        for (c = 0; c < COLS; c = c + 1) begin : g_col
            always @(posedge clk) begin
                if (rst) begin
                    colPolarity[c] <= 1'b0;
                end else begin
                    // Neighbouring columns always drive opposite polarity
                    colPolarity[c] <= framePol_q ^ line_q[0]
                        ^ (c % 2 == 1);
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (rst) begin
            colLevel <= 6'h00;
            grayAdjActive <= 38'h0;
        end else begin
            colLevel <= pixelLevel;
            // Even columns pick the set that matches their polarity
            if (framePol_q ^ line_q[0]) begin
                grayAdjActive <= grayAdjNeg;
            end else begin
                grayAdjActive <= grayAdjPos;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync output
    always @* begin
        if (syncMode_q == `PST_MODE_VBLANK) begin
            // Delay counts lines from the first visible row
            if (syncLineDelay == 9'd0) begin
                syncRaw = (state_q == ST_VBLANK);
            end else begin
                // High stretches over the first delay-1 visible lines
                syncRaw = (state_q == ST_VBLANK)
                    || ((state_q != ST_VBLANK)
                    && (line_q + 9'd1 < syncLineDelay));
            end
        end else begin
            // Mode 2 follows both vertical and horizontal blanking
            syncRaw = (state_q != ST_ACTIVE);
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            highCnt_q <= 20'd0;
            panelSyncPulse <= 1'b0;
            baseTickOut <= 1'b0;
        end else begin
            baseTickOut <= baseTick;
            if (!panelSyncPulse || state_q == ST_VBLANK) begin
                highCnt_q <= 20'd0;
            end else begin
                highCnt_q <= highCnt_q + 20'd1;
            end
            if (sleepIn || rgbIfActive || !syncEn_q) begin
                panelSyncPulse <= 1'b0;
            end else if (syncMode_q == `PST_MODE_VHBLANK && state_q != ST_VBLANK
                && highCnt_q >= HHIGH_CYC - 1) begin
                panelSyncPulse <= 1'b0;
            end else begin
                panelSyncPulse <= syncRaw;
            end
        end
    end
endmodule // pst_panel_timing

// ---- include/pst_map.vh ----
`ifndef PST_MAP_VH
`define PST_MAP_VH
// Panel geometry
`define PST_ROWS 320
`define PST_COLS 720
`define PST_GRAY_LEVELS 64
// Sync output modes
`define PST_MODE_VBLANK 1'b0
`define PST_MODE_VHBLANK 1'b1
// Oscillator
`define PST_BASE_KHZ 2850
`define PST_CLK_KHZ 250000
`define PST_TRIM_RESET 4'h8
// Line timing in base clock ticks, vertical blanking in lines
`define PST_LINE_TICKS 16'd190
`define PST_LINE_BLANK_TICKS 16'd40
`define PST_VBLANK_LINES 9'd8
// Longest horizontal high interval of the sync output
`define PST_HHIGH_MAX_US 500
`endif

// ---- sim/pst_host_model.sv ----
`timescale 1ns/1ps
module pst_host_model (
    input wire clk,
    input wire panelSyncPulse,
    output reg syncOnCmd = 1'b0,
    output reg syncOffCmd = 1'b0,
    output reg [7:0] syncOnParam = 8'h0,
    output reg writeWindow = 1'b0
);
    // One-cycle command; the parameter byte is not held afterwards
    task sendCmd(input reg on, input reg [7:0] prm);
        begin
            @(negedge clk);
            syncOnCmd = on;
            syncOffCmd = !on;
            syncOnParam = prm;
            @(negedge clk);
            syncOnCmd = 1'b0;
            syncOffCmd = 1'b0;
            syncOnParam = ~prm;
        end
    endtask
    // Writes start on the pulse, so they lead or trail the scan
    always @(posedge clk) writeWindow <= panelSyncPulse;
endmodule // pst_host_model

// ---- sim/pst_panel_timing_assertions.sv ----
`timescale 1ns/1ps
module pst_panel_timing_assertions #(
    parameter ROWS = 320,
    parameter CLK_KHZ = 250000
) (
    input wire clk,
    input wire rst,
    input wire syncOnCmd,
    input wire syncOffCmd,
    input wire rgbIfActive,
    input wire sleepIn,
    input wire [37:0] grayAdjPos,
    input wire [37:0] grayAdjNeg,
    input wire panelSyncPulse,
    input wire [ROWS-1:0] rowOn,
    input wire [37:0] grayAdjActive,
    input wire baseTickOut
);
    localparam integer HMAX = 500 * CLK_KHZ / 1000;
    reg [31:0] hiCnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Length of a high stretch while a row is scanned
    always @(posedge clk) begin
        if (rst || !panelSyncPulse || rowOn == 0)
            hiCnt_q <= 32'h0;
        else
            hiCnt_q <= hiCnt_q + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_OFF_LOW: assert property (
        syncOffCmd && !syncOnCmd ##1 !syncOnCmd [*2] |-> !panelSyncPulse)
        else $error("Sync output high after off");
    AST_RGB_LOW: assert property (
        rgbIfActive [*3] |-> !panelSyncPulse)
        else $error("Sync output high with pixel port active");
    AST_SLEEP_LOW: assert property (
        sleepIn [*3] |-> !panelSyncPulse)
        else $error("Sync output high in sleep");
    AST_HIGH_CAP: assert property (
        hiCnt_q <= HMAX) else $error("Line high interval too long");
    AST_ROW_ONE: assert property (
        $onehot0(rowOn)) else $error("More than one row on");
    AST_TICK_PULSE: assert property (
        baseTickOut |=> !baseTickOut) else $error("Base tick wider");
    AST_TICK_RATE: assert property (
        baseTickOut |-> ##[2:40] baseTickOut) else $error("Base tick lost");
    AST_GRAY_SET: assert property (
        $changed(grayAdjActive) |-> grayAdjActive == grayAdjPos ||
        grayAdjActive == grayAdjNeg) else $error("Gray set not selected");
    cover property ($rose(panelSyncPulse));
    cover property (sleepIn && syncOnCmd);
    cover property (rowOn[0] ##[1:1000] rowOn[ROWS-1]);
endmodule // pst_panel_timing_assertions

bind pst_panel_timing pst_panel_timing_assertions #(.ROWS(ROWS),
    .CLK_KHZ(CLK_KHZ)) pst_panel_timing_assertions_i (.clk(clk), .rst(rst),
    .syncOnCmd(syncOnCmd), .syncOffCmd(syncOffCmd), .sleepIn(sleepIn),
    .rgbIfActive(rgbIfActive), .grayAdjPos(grayAdjPos),
    .grayAdjNeg(grayAdjNeg), .panelSyncPulse(panelSyncPulse),
    .rowOn(rowOn), .grayAdjActive(grayAdjActive), .baseTickOut(baseTickOut));

// ---- sim/pst_panel_timing_tb.sv ----
`timescale 1ns/1ps
module pst_panel_timing_tb;
    localparam ROWS = 4;
    localparam FT = (8 + ROWS) * 190;
    reg clk = 1'b0, rst = 1'b1, rgbIfActive = 1'b0, sleepIn = 1'b0;
    reg rowInterleave = 1'b0, rowOrderFlip = 1'b0;
    reg [8:0] syncLineDelay = 9'h0;
    reg [3:0] oscFreqTrim = 4'h8;
    reg [5:0] pixelLevel = 6'h0;
    reg [37:0] grayAdjPos = 38'h0, grayAdjNeg = 38'h0;
    reg [63:0] rnd;
    wire syncOnCmd, syncOffCmd, writeWindow, panelSyncPulse, baseTickOut;
    wire [7:0] syncOnParam;
    wire [ROWS-1:0] rowOn;
    wire [719:0] colPolarity;
    wire [5:0] colLevel;
    wire [37:0] grayAdjActive;
    integer seed = 32'h723d, error_cnt = 0, check_count = 0, cyc = 0;
    integer hi, rises, i, j;
    pst_host_model pst_host_model_i (.clk(clk), .panelSyncPulse(panelSyncPulse),
        .syncOnCmd(syncOnCmd), .syncOffCmd(syncOffCmd),
        .syncOnParam(syncOnParam), .writeWindow(writeWindow));
    pst_panel_timing #(.ROWS(ROWS), .CLK_KHZ(5700)) pst_panel_timing_i (
        .clk(clk), .rst(rst), .syncOnCmd(syncOnCmd), .syncOffCmd(syncOffCmd),
        .syncOnParam(syncOnParam), .rgbIfActive(rgbIfActive),
        .sleepIn(sleepIn), .syncLineDelay(syncLineDelay),
        .oscFreqTrim(oscFreqTrim), .rowInterleave(rowInterleave),
        .rowOrderFlip(rowOrderFlip), .pixelLevel(pixelLevel),
        .grayAdjPos(grayAdjPos), .grayAdjNeg(grayAdjNeg),
        .panelSyncPulse(panelSyncPulse), .rowOn(rowOn),
        .colPolarity(colPolarity), .colLevel(colLevel),
        .grayAdjActive(grayAdjActive), .baseTickOut(baseTickOut));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 99000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // High ticks and rising edges over one field, after optional settling
    task measure(input integer settle);
        integer n;
        reg last;
        begin
            repeat (4) @(negedge clk);
            hi = 0;
            rises = 0;
            n = 0;
            last = panelSyncPulse;
            while (n < FT * (1 + settle)) begin
                @(negedge clk);
                pixelLevel = $random(seed);
                if (baseTickOut === 1'b1) begin
                    n = n + 1;
                    if (n > FT * settle) begin
                        hi = hi + panelSyncPulse;
                        rises = rises + (panelSyncPulse & ~last);
                    end
                    last = panelSyncPulse;
                end
            end
        end
    endtask
    function integer expRow(input integer n, input reg il, input reg fl);
        begin
            if (!il)
                expRow = fl ? ROWS - 1 - n : n;
            else if (n < ROWS / 2)
                expRow = fl ? ROWS - 1 - 2 * n : 2 * n;
            else
                expRow = fl ? ROWS - 2 - 2 * (n - ROWS / 2) :
                    2 * (n - ROWS / 2) + 1;
        end
    endfunction
    initial begin
        rnd = {$random(seed), $random(seed)};
        grayAdjPos = rnd[37:0];
        rnd = {$random(seed), $random(seed)};
        grayAdjNeg = rnd[37:0];
        oscFreqTrim = 4'h8;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        pst_host_model_i.sendCmd(1'b1, 8'h01);
        measure(1);
        check(rises, ROWS);
        check(hi, 8 * 190 + ROWS * 40);
        @(negedge clk);
        pixelLevel = $random(seed);
        j = pixelLevel;
        @(negedge clk);
        check(colLevel, j);
        check(colPolarity[0] ^ colPolarity[1], 1);
        check(grayAdjActive[31:0], colPolarity[0] ? grayAdjNeg[31:0] :
            grayAdjPos[31:0]);
        $display("test mode2 done");
        for (i = 0; i < 3; i = i + 1) begin
            syncLineDelay = (i < 2) ? i * 2 : 1 + {$random(seed)} % (ROWS - 1);
            pst_host_model_i.sendCmd(1'b1, 8'hfe);
            measure(1);
            j = (syncLineDelay > 0) ? syncLineDelay - 1 : 0;
            check(hi, (8 + j) * 190);
            check(rises, 1);
            $display("test mode1 delay %0d done", syncLineDelay);
        end
        for (i = 0; i < 3; i = i + 1) begin
            sleepIn = (i == 0);
            rgbIfActive = (i == 1);
            pst_host_model_i.sendCmd(i != 2, 8'h01);
            measure(0);
            check(hi, 0);
            $display("test blocked output %0d done", i);
        end
        for (i = 0; i < 4; i = i + 1) begin
            rowInterleave = i[1];
            rowOrderFlip = i[0];
            j = 0;
            while (j < 500) begin
                @(negedge clk);
                j = (rowOn === 0) ? j + 1 : 0;
            end
            for (j = 0; j < ROWS; j = j + 1) begin
                while (rowOn === 0 || (j > 0 && rowOn[expRow(j - 1, i[1],
                    i[0])] === 1'b1)) @(negedge clk);
                check(rowOn, 1 << expRow(j, i[1], i[0]));
            end
            $display("test scan order %0d done", i);
        end
        conclude;
    end
endmodule // pst_panel_timing_tb
